// ===== include/pwr_state_pkg.sv
// Purpose: shared constants and types for the power-state and wake controller
// Assumes: 125 MHz system clock, all inputs synchronous to it
// Notes:   state encodings are one-hot; timing counts derive from printed times
package pwr_state_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_FREQ_HZ      = 125_000_000;
  localparam int unsigned LONG_PRESS_S     = 4;
  localparam longint unsigned LONG_PRESS_CYC = longint'(LONG_PRESS_S) * longint'(CLK_FREQ_HZ);
  localparam int unsigned PWM_STEPS        = 256;
  localparam int unsigned PWM_DIV          = 16;

  // ==========================================================================
  // power states, one-hot
  typedef enum logic [5:0] {
    ST_S0  = 6'h01,
    ST_S1  = 6'h02,
    ST_S3  = 6'h04,
    ST_S4  = 6'h08,
    ST_S5  = 6'h10,
    ST_OFF = 6'h20
  } pwr_state_t;

  // ==========================================================================
  // wake source positions in the wake vector
  localparam int unsigned WK_PWRSW  = 0;
  localparam int unsigned WK_LAN    = 1;
  localparam int unsigned WK_PME    = 2;
  localparam int unsigned WK_PCIE   = 3;
  localparam int unsigned WK_PS2    = 4;
  localparam int unsigned WK_RTC    = 5;
  localparam int unsigned WK_SERIAL = 6;
  localparam int unsigned WK_USB    = 7;
  localparam int unsigned WK_NUM    = 8;

  // per-state permission masks, one bit per source
  localparam logic [7:0] ALLOW_S1 = 8'h1F;
  localparam logic [7:0] ALLOW_S3 = 8'hFF;
  localparam logic [7:0] ALLOW_S4 = 8'h2F;
  localparam logic [7:0] ALLOW_S5 = 8'h2F;

  // ==========================================================================
  // firmware options
  typedef struct packed {
    logic lan_s5_en;     // lan may wake from s5
    logic pme_en;        // pme line may wake at all
    logic pme_s5_en;     // pme may wake from s5
    logic restore_last;  // return to last state after ac loss
  } fw_opt_t;

  // supply and indicator outputs
  typedef struct packed {
    logic main_on;
    logic led_green;
    logic led_amber;
  } pwr_out_t;

  localparam logic RST_MAIN_ON = 1'b0;
  localparam logic RST_FAN_ON  = 1'b0;

endpackage

// ===== verilog/press_timer.sv
// Purpose: classify power-switch presses as short or long
// Assumes: button input synchronous and already clean
// Notes:   long pulse fires once, at the threshold, while still pressed
`timescale 1ns/100ps
`default_nettype none
module press_timer
  import pwr_state_pkg::*;
#(
  parameter longint unsigned LONG_CYC = LONG_PRESS_CYC
) (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_b_i,
  // button
  input  wire logic press_i,
  // classified events
  output logic      short_o,
  output logic      long_o
);

  initial begin
    if (LONG_CYC < 2) $error("press_timer: LONG_CYC too small");
  end

  logic [39:0] cnt_q, cnt_d;
  logic        fired_q, fired_d;
  logic        prev_q, prev_d;
  logic        short_q, short_d;
  logic        long_q, long_d;

  // count held time; a release before threshold is a short press
  always_comb begin
    cnt_d   = cnt_q;
    fired_d = fired_q;
    prev_d  = press_i;
    short_d = 1'b0;
    long_d  = 1'b0;
    if (press_i) begin
      if (!fired_q) begin
        if (cnt_q == 40'(LONG_CYC - 1)) begin
          long_d  = 1'b1;
          fired_d = 1'b1;
        end else begin
          cnt_d = cnt_q + 40'h1;
        end
      end
    end else begin
      if (prev_q && !fired_q) short_d = 1'b1;
      cnt_d   = 40'h0;
      fired_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      cnt_q   <= 40'h0;
      fired_q <= 1'b0;
      prev_q  <= 1'b0;
      short_q <= 1'b0;
      long_q  <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      fired_q <= fired_d;
      prev_q  <= prev_d;
      short_q <= short_d;
      long_q  <= long_d;
    end
  end

  assign short_o = short_q;
  assign long_o  = long_q;

endmodule
`default_nettype wire

// ===== verilog/fan_pwm.sv
// Purpose: per-channel fan drive with duty control and full on/off
// Assumes: duty from an outside loop controller, tach shared per channel pair
// Notes:   one pwm step per divider enable pulse
`timescale 1ns/100ps
`default_nettype none
module fan_pwm
  import pwr_state_pkg::*;
#(
  parameter int unsigned N_FAN = 4
) (
  // clock and reset
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_b_i,
  // control
  input  wire logic                 fan_en_i,
  input  wire logic [N_FAN-1:0]     full_i,
  input  wire logic [N_FAN*8-1:0]   duty_i,
  input  wire logic [N_FAN/2-1:0]   tach_i,
  // drive
  output logic      [N_FAN-1:0]     pwm_o,
  output logic      [N_FAN-1:0]     tach_o
);

  initial begin
    if (N_FAN < 2 || N_FAN % 2 != 0) $error("fan_pwm: N_FAN must be even");
  end

  logic [3:0]       div_q, div_d;
  logic [7:0]       ph_q, ph_d;
  logic [N_FAN-1:0] pwm_q, pwm_d;

  // divider makes the slow pwm step enable
  always_comb begin
    div_d = (div_q == 4'(PWM_DIV - 1)) ? 4'h0 : div_q + 4'h1;
    ph_d  = (div_q == 4'(PWM_DIV - 1)) ? ph_q + 8'h01 : ph_q;
  end

  // each channel: off, fully on, or duty compare
  genvar g;
  generate
    for (g = 0; g < N_FAN; g++) begin : g_ch
      assign pwm_d[g]  = fan_en_i & (full_i[g] | (ph_q < duty_i[g*8 +: 8]));
      assign tach_o[g] = tach_i[g/2];
    end
  endgenerate

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      div_q <= 4'h0;
      ph_q  <= 8'h00;
      pwm_q <= '0;
    end else begin
      div_q <= div_d;
      ph_q  <= ph_d;
      pwm_q <= pwm_d;
    end
  end

  assign pwm_o = pwm_q;

endmodule
`default_nettype wire

// ===== verilog/wake_power_ctrl.sv
// Purpose: track sleeping states, qualify wake sources, drive supply/fan/led
// Assumes: all inputs synchronous to clk_sys_i and on standby power
// Notes:   the os requests sleep states; the switch and wakes return to s0
`timescale 1ns/100ps
`default_nettype none

module wake_power_ctrl
  import pwr_state_pkg::*;
#(
  parameter longint unsigned LONG_CYC = LONG_PRESS_CYC,
  parameter int unsigned     N_FAN    = 4
) (
  // clock and reset
  input  wire logic               clk_sys_i,
  input  wire logic               rst_b_i,
  // firmware options
  input  wire fw_opt_t            opt_i,
  // ac power status and os requests
  input  wire logic               ac_ok_i,
  input  wire logic               os_s1_i,
  input  wire logic               os_s3_i,
  input  wire logic               os_s4_i,
  input  wire logic               os_s5_i,
  // wake sources, active high after board inversion
  input  wire logic               pwr_sw_i,
  input  wire logic               lan_wake_i,
  input  wire logic               pme_i,
  input  wire logic               pcie_wake_i,
  input  wire logic               ps2_act_i,
  input  wire logic               rtc_alarm_i,
  input  wire logic               serial_act_i,
  input  wire logic               usb_act_i,
  // fan control
  input  wire logic [N_FAN-1:0]   fan_full_i,
  input  wire logic [N_FAN*8-1:0] fan_duty_i,
  input  wire logic [N_FAN/2-1:0] fan_tach_i,
  // outputs
  output pwr_out_t                pwr_o,
  output logic                    fan_pwr_o,
  output logic [N_FAN-1:0]        fan_pwm_o,
  output logic [N_FAN-1:0]        fan_tach_o,
  output logic [5:0]              state_o,
  output logic                    wake_req_o
);

  // ==========================================================================
  // power switch classification
  logic sw_short;
  logic sw_long;

  press_timer #(
    .LONG_CYC (LONG_CYC)
  ) u_press (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .press_i   (pwr_sw_i),
    .short_o   (sw_short),
    .long_o    (sw_long)
  );

  // ==========================================================================
  // wake qualification
  pwr_state_t          st_q, st_d;
  logic [WK_NUM-1:0]   wk_raw;
  logic [WK_NUM-1:0]   wk_allow;
  logic                wk_any;

  // the switch is handled by the press timer, so bit 0 stays out of the merge
  always_comb begin
    wk_raw            = '0;
    wk_raw[WK_LAN]    = lan_wake_i;
    wk_raw[WK_PME]    = pme_i;
    wk_raw[WK_PCIE]   = pcie_wake_i;
    wk_raw[WK_PS2]    = ps2_act_i;
    wk_raw[WK_RTC]    = rtc_alarm_i;
    wk_raw[WK_SERIAL] = serial_act_i;
    wk_raw[WK_USB]    = usb_act_i;
  end

  // per-state permission table, then firmware gates
  always_comb begin
    case (st_q)
      ST_S1:   wk_allow = ALLOW_S1;
      ST_S3:   wk_allow = ALLOW_S3;
      ST_S4:   wk_allow = ALLOW_S4;
      ST_S5:   wk_allow = ALLOW_S5;
      default: wk_allow = '0;
    endcase
    if (!opt_i.pme_en) wk_allow[WK_PME] = 1'b0;
    if (st_q == ST_S5) begin
      if (!opt_i.lan_s5_en) wk_allow[WK_LAN] = 1'b0;
      if (!opt_i.pme_s5_en) wk_allow[WK_PME] = 1'b0;
    end
  end

  assign wk_any = |(wk_raw & wk_allow);

  // ==========================================================================
  // wake latch: held until the power-up step takes it
  logic wreq_q, wreq_d;
  logic power_up;

  // set wins over the clear made by the power-up step
  always_comb begin
    wreq_d = wreq_q;
    if (power_up) wreq_d = 1'b0;
    if (wk_any) wreq_d = 1'b1;
  end

  // ==========================================================================
  // state machine
  logic       last_on_q, last_on_d;
  logic       ac_q, ac_d;
  logic       fan_q, fan_d;
  pwr_out_t   out_q, out_d;

  assign power_up = (st_q != ST_S0) && (st_d == ST_S0);

  // long press dominates in s0, s1, s3 and s4; wakes only act in sleeping states
  always_comb begin
    st_d      = st_q;
    last_on_d = last_on_q;
    ac_d      = ac_ok_i;
    if (!ac_q && ac_ok_i) begin
      // ac return: restore the remembered state, else stay off
      st_d = (opt_i.restore_last && last_on_q) ? ST_S0 : ST_OFF;
      // the state we come back in becomes the one a later loss restores
      last_on_d = (st_d == ST_S0);
    end else if (!ac_q) begin
      st_d = ST_OFF;
    end else begin
      case (st_q)
        ST_S0: begin
          if (sw_long) st_d = ST_OFF;
          else if (sw_short || os_s1_i) st_d = ST_S1;
          else if (os_s3_i) st_d = ST_S3;
          else if (os_s4_i) st_d = ST_S4;
          else if (os_s5_i) st_d = ST_OFF;
        end
        ST_S1, ST_S3, ST_S4: begin
          if (sw_long) st_d = ST_OFF;
          else if (sw_short || wreq_q) st_d = ST_S0;
        end
        ST_S5: begin
          if (sw_short || wreq_q) st_d = ST_S0;
        end
        ST_OFF: begin
          if (sw_short) st_d = ST_S0;
        end
        default: st_d = ST_OFF;
      endcase
      // soft-off from s0 lands in s5 so wakes keep working
      if (st_q == ST_S0 && (sw_long || os_s5_i)) st_d = ST_S5;
      if (st_d == ST_S0) last_on_d = 1'b1;
      else if (st_d == ST_S5 || st_d == ST_OFF) last_on_d = 1'b0;
    end
  end

  // outputs derived from next state so they stand registered
  always_comb begin
    out_d.main_on   = (st_d == ST_S0) | (st_d == ST_S1);
    out_d.led_green = (st_d == ST_S0);
    out_d.led_amber = (st_d == ST_S3) | (st_d == ST_S1);
    fan_d           = (st_d == ST_S0);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      st_q      <= ST_OFF;
      last_on_q <= 1'b0;
      ac_q      <= 1'b0;
      wreq_q    <= 1'b0;
      fan_q     <= RST_FAN_ON;
      out_q     <= '{main_on: RST_MAIN_ON, led_green: 1'b0, led_amber: 1'b0};
    end else begin
      st_q      <= st_d;
      last_on_q <= last_on_d;
      ac_q      <= ac_d;
      wreq_q    <= wreq_d;
      fan_q     <= fan_d;
      out_q     <= out_d;
    end
  end

  // ==========================================================================
  // fan drive
  fan_pwm #(
    .N_FAN (N_FAN)
  ) u_fan (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .fan_en_i  (fan_q),
    .full_i    (fan_full_i),
    .duty_i    (fan_duty_i),
    .tach_i    (fan_tach_i),
    .pwm_o     (fan_pwm_o),
    .tach_o    (fan_tach_o)
  );

  assign pwr_o      = out_q;
  assign fan_pwr_o  = fan_q;
  assign state_o    = st_q;
  assign wake_req_o = wreq_q;

endmodule
`default_nettype wire

// ===== dv/wake_power_ctrl_assertions.sv
// Purpose: port-level checks of the power-state and wake controller
// Assumes: one clock, synchronous active-low reset
// Notes:   sees only the top module's ports; bound at the foot
`timescale 1ns/100ps
`default_nettype none
module wake_power_chk
  import pwr_state_pkg::*;
(
  // clock and reset
  input wire logic       clk_sys_i,
  input wire logic       rst_b_i,
  // options and wake sources
  input wire fw_opt_t    opt_i,
  input wire logic       ac_ok_i,
  input wire logic       pwr_sw_i,
  input wire logic       lan_wake_i,
  input wire logic       pme_i,
  input wire logic       pcie_wake_i,
  input wire logic       ps2_act_i,
  input wire logic       rtc_alarm_i,
  input wire logic       serial_act_i,
  input wire logic       usb_act_i,
  // outputs watched
  input wire pwr_out_t   pwr_o,
  input wire logic       fan_pwr_o,
  input wire logic [5:0] state_o,
  input wire logic       wake_req_o
);
  logic [7:0] wk;
  logic       slp;
  // wake vector in source order; lone-source checks need all others quiet
  assign wk  = {usb_act_i, serial_act_i, rtc_alarm_i, ps2_act_i, pcie_wake_i, pme_i, lan_wake_i, pwr_sw_i};
  assign slp = state_o inside {ST_S1, ST_S3, ST_S4, ST_S5};
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  // ==========================================================================
  // properties
  chk_fan_follow: assert property (fan_pwr_o == (state_o == ST_S0))
    else $error("fan power not tied to working state");
  chk_s3_amber: assert property (state_o == ST_S3 |-> !pwr_o.main_on && pwr_o.led_amber)
    else $error("s3 supply or indicator wrong");
  chk_s3_wake: assert property (state_o == ST_S3 && usb_act_i |=> wake_req_o ##1 state_o == ST_S0)
    else $error("usb wake from s3 not honoured");
  chk_usb_refused: assert property (slp && state_o != ST_S3 && wk == 8'h80 && !wake_req_o |=> !wake_req_o)
    else $error("usb woke outside s3");
  chk_rtc_s1: assert property (state_o == ST_S1 && wk == 8'h20 && !wake_req_o |=> state_o == ST_S1)
    else $error("rtc woke from s1");
  chk_pcie_wake: assert property (state_o inside {ST_S3, ST_S4, ST_S5} && pcie_wake_i && ac_ok_i |-> ##[1:3] state_o == ST_S0)
    else $error("pcie wake ignored");
  chk_pme_gate: assert property (slp && !opt_i.pme_en && wk == 8'h04 && !wake_req_o |=> !wake_req_o)
    else $error("pme woke while disabled");
  chk_lan_s5: assert property (state_o == ST_S5 && !opt_i.lan_s5_en && wk == 8'h02 && !wake_req_o |=> state_o == ST_S5)
    else $error("lan woke s5 while disabled");
  chk_req_s0: assert property ($rose(wake_req_o) |=> state_o == ST_S0)
    else $error("wake request did not reach s0");
  chk_off_dark: assert property (state_o == ST_OFF |-> !pwr_o.main_on && !fan_pwr_o)
    else $error("supply or fan on while off");
endmodule
bind wake_power_ctrl wake_power_chk u_chk (.clk_sys_i, .rst_b_i, .opt_i, .ac_ok_i, .pwr_sw_i, .lan_wake_i, .pme_i,
  .pcie_wake_i, .ps2_act_i, .rtc_alarm_i, .serial_act_i, .usb_act_i, .pwr_o, .fan_pwr_o, .state_o, .wake_req_o);
`default_nettype wire

// ===== dv/pwr_far_model.sv
// Purpose: supply and network peer facing the controller
// Assumes: driven off the falling edge, like the bench
// Notes:   wake output is one cycle per frame so it never sticks
`timescale 1ns/100ps
`default_nettype none
module pwr_far_model (
  // clock
  input  wire logic clk_sys_i,
  // controls
  input  wire logic main_on_i,
  input  wire logic frame_i,
  // answers
  output logic      lan_wake_o,
  output logic      rails_o,
  output logic      stby_o
);
  logic frame_q;
  initial begin
    lan_wake_o = 1'b0;
    rails_o    = 1'b0;
    frame_q    = 1'b0;
  end
  // network side: wake pulse on each new remote frame
  always @(negedge clk_sys_i) begin
    lan_wake_o <= frame_i && !frame_q;
    frame_q    <= frame_i;
  end
  // supply: non-standby rails follow the command, standby stays
  always @(negedge clk_sys_i) begin
    rails_o <= main_on_i;
  end
  assign stby_o = 1'b1;
endmodule
`default_nettype wire

// ===== dv/wake_power_ctrl_tb.sv
// Purpose: self-checking bench for the power-state controller
// Assumes: long press shortened to 20 cycles
// Notes:   inputs change on the falling edge only
`timescale 1ns/100ps
`default_nettype none
module wake_power_ctrl_tb;
  import pwr_state_pkg::*;
  logic            clk_sys_i = 1'b0;
  logic            rst_b_i   = 1'b0;
  fw_opt_t         opt       = '0;
  logic            ac_ok     = 1'b1;
  logic [3:0]      os        = 4'h0;
  logic [7:0]      wk        = 8'h00;
  logic [3:0]      full      = 4'h0;
  logic [31:0]     duty      = 32'h40404040;
  logic [1:0]      tach      = 2'h0;
  pwr_out_t        pwr;
  logic            fan_pwr;
  logic            wreq;
  logic            lan_w;
  logic            rails;
  logic            stby;
  logic [3:0]      pwm;
  logic [3:0]      tacho;
  logic [5:0]      st;
  int              n_fail    = 0;
  int              checks    = 0;
  int              cyc       = 0;
  // ==========================================================================
  // clock, instances, watchdog
  always #4 clk_sys_i = ~clk_sys_i;
  wake_power_ctrl #(.LONG_CYC(20), .N_FAN(4)) dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .opt_i(opt),
    .ac_ok_i(ac_ok), .os_s1_i(os[0]), .os_s3_i(os[1]), .os_s4_i(os[2]), .os_s5_i(os[3]), .pwr_sw_i(wk[0]),
    .lan_wake_i(lan_w), .pme_i(wk[2]), .pcie_wake_i(wk[3]), .ps2_act_i(wk[4]), .rtc_alarm_i(wk[5]),
    .serial_act_i(wk[6]), .usb_act_i(wk[7]), .fan_full_i(full), .fan_duty_i(duty), .fan_tach_i(tach),
    .pwr_o(pwr), .fan_pwr_o(fan_pwr), .fan_pwm_o(pwm), .fan_tach_o(tacho), .state_o(st), .wake_req_o(wreq));
  pwr_far_model far (.clk_sys_i(clk_sys_i), .main_on_i(pwr.main_on), .frame_i(wk[1]), .lan_wake_o(lan_w),
    .rails_o(rails), .stby_o(stby));
  // a hang counts as a mismatch; ceiling is several times the expected run
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      give_verdict();
    end
  end
  // ==========================================================================
  // shared tasks
  task automatic give_verdict();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic pulse_wk(input int b);
    wk[b] = 1'b1;
    tick(1);
    wk[b] = 1'b0;
    tick(6);
  endtask
  task automatic pulse_os(input int k);
    os[k] = 1'b1;
    tick(1);
    os[k] = 1'b0;
    tick(4);
  endtask
  task automatic press(input int n);
    wk[0] = 1'b1;
    tick(n);
    wk[0] = 1'b0;
    tick(6);
  endtask
  // per-state permission: index 0..3 is s1, s3, s4, s5
  function automatic logic allowed(input int s, input int b, input fw_opt_t o);
    logic [7:0] m;
    m = (s == 1) ? 8'hFF : (s == 0) ? 8'h1F : 8'h2F;
    if (!o.pme_en || (s == 3 && !o.pme_s5_en)) m[2] = 1'b0;
    if (s == 3 && !o.lan_s5_en) m[1] = 1'b0;
    return m[b];
  endfunction
  // ==========================================================================
  // scenarios
  task automatic run_press();
    press(3);
    cmp({2'h0, st}, 8'h01);
    cmp({6'h0, rails, stby}, 8'h03);
    press(25);
    cmp({2'h0, st}, 8'h10);
    cmp({6'h0, rails, stby}, 8'h01);
    press(3);
    cmp({2'h0, st}, 8'h01);
    pulse_os(1);
    press(25);
    cmp({2'h0, st}, 8'h20);
    press(3);
  endtask
  task automatic run_wake_table(input fw_opt_t o);
    opt = o;
    for (int s = 0; s < 4; s++) begin
      for (int b = 1; b < 8; b++) begin
        pulse_os(s);
        cmp({2'h0, st}, {2'h0, 6'h02 << s});
        cmp({7'h0, fan_pwr}, 8'h00);
        if (s == 1) cmp({5'h0, pwr}, 8'h01);
        pulse_wk(b);
        cmp({2'h0, st}, allowed(s, b, o) ? 8'h01 : {2'h0, 6'h02 << s});
        if (st !== ST_S0) pulse_wk(3);
        cmp({2'h0, st}, 8'h01);
        cmp({4'h0, pwr, fan_pwr}, 8'h0D);
      end
    end
  endtask
  task automatic run_fan();
    for (int t = 0; t < 4; t++) begin
      tach = t[1:0];
      tick(1);
      cmp({4'h0, tacho}, {4'h0, t[1], t[1], t[0], t[0]});
    end
    full = 4'hF;
    tick(4);
    cmp({4'h0, pwm}, 8'h0F);
    pulse_os(1);
    tick(2);
    cmp({4'h0, pwm}, 8'h00);
    pulse_wk(7);
    full = 4'h0;
  endtask
  task automatic run_ac();
    opt = 4'h1;
    ac_ok = 1'b0;
    tick(3);
    cmp({2'h0, st}, 8'h20);
    ac_ok = 1'b1;
    tick(6);
    cmp({2'h0, st}, 8'h01);
    opt = 4'h0;
    ac_ok = 1'b0;
    tick(3);
    ac_ok = 1'b1;
    tick(6);
    cmp({2'h0, st}, 8'h20);
    opt = 4'h1;
    ac_ok = 1'b0;
    tick(3);
    ac_ok = 1'b1;
    tick(6);
    cmp({2'h0, st}, 8'h20);
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    tick(16);
    rst_b_i = 1'b1;
    tick(2);
    run_press();
    run_wake_table(4'hE);
    run_wake_table(4'h0);
    run_fan();
    run_ac();
    give_verdict();
  end
endmodule
`default_nettype wire
